// file: design/mode_cfg_regs.sv
`timescale 1ns/10ps
`default_nettype none
module mode_cfg_regs (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic wr_en_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] rdata_out,
   input wire logic compat_strap_in,
   input wire logic range_strap_in,
   input wire logic crc_check_en_in,
   output logic failsafe_low_out,
   output logic crc_cnt_clear_out,
   output logic crc_check_en_out,
   output logic legacy_compat_out,
   output logic low_freq_range_sel_out
);
   logic [7:0] cfg_reg;
   logic [7:0] bus_ctl_reg;
   logic [7:0] rdata_reg;

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   // bit 5 is cleared here only by reset: otherwise software must write it back to 0
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cfg_reg <= mode_cfg_pkg::cfg_reset;
      end else if (wr_en_in && addr_in == mode_cfg_pkg::cfg_offset) begin
         cfg_reg <= wdata_in & mode_cfg_pkg::cfg_writable;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         bus_ctl_reg <= mode_cfg_pkg::bus_ctl_reset;
      end else if (wr_en_in && addr_in == mode_cfg_pkg::bus_ctl_offset) begin
         bus_ctl_reg <= wdata_in & mode_cfg_pkg::bus_ctl_writable;
      end
   end

   // ----------------------------------------
   // read back, registered; unmapped reads zero
   // ----------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rdata_reg <= 8'h00;
      end else if (addr_in == mode_cfg_pkg::cfg_offset) begin
         rdata_reg <= cfg_reg;
      end else if (addr_in == mode_cfg_pkg::bus_ctl_offset) begin
         rdata_reg <= bus_ctl_reg;
      end else begin
         rdata_reg <= 8'h00;
      end
   end
   assign rdata_out = rdata_reg;

   // ----------------------------------------
   // outputs to the rest of the device
   // ----------------------------------------
   assign failsafe_low_out = cfg_reg[mode_cfg_pkg::failsafe_low_bit];
   assign crc_cnt_clear_out = cfg_reg[mode_cfg_pkg::crc_clear_bit];
   // checker enable lives in another register outside this block
   assign crc_check_en_out = crc_check_en_in;

   cfg_field_sel compat_sel (
      .by_reg_in(cfg_reg[mode_cfg_pkg::compat_by_reg_bit]),
      .reg_val_in(cfg_reg[mode_cfg_pkg::compat_val_bit]),
      .strap_in(compat_strap_in),
      .sel_out(legacy_compat_out)
   );

   cfg_field_sel range_sel (
      .by_reg_in(cfg_reg[mode_cfg_pkg::range_by_reg_bit]),
      .reg_val_in(cfg_reg[mode_cfg_pkg::range_val_bit]),
      .strap_in(range_strap_in),
      .sel_out(low_freq_range_sel_out)
   );

   // ----------------------------------------
   // checks
   // ----------------------------------------
   chk_failsafe_follows: assert property (@(posedge clk_in) disable iff (rst_in)
      failsafe_low_out == cfg_reg[7]) else $error("failsafe level wrong");
   chk_clear_holds: assert property (@(posedge clk_in) disable iff (rst_in)
      crc_cnt_clear_out && !(wr_en_in && addr_in == 8'h04) |=> crc_cnt_clear_out)
      else $error("crc clear dropped by itself");
   chk_compat_reg: assert property (@(posedge clk_in) disable iff (rst_in)
      cfg_reg[3] |-> legacy_compat_out == cfg_reg[2]) else $error("compat not from reg");
   chk_compat_strap: assert property (@(posedge clk_in) disable iff (rst_in)
      !cfg_reg[3] |-> legacy_compat_out == compat_strap_in) else $error("compat not from strap");
   chk_range_reg: assert property (@(posedge clk_in) disable iff (rst_in)
      cfg_reg[1] |-> low_freq_range_sel_out == cfg_reg[0]) else $error("range not from reg");
   chk_range_strap: assert property (@(posedge clk_in) disable iff (rst_in)
      !cfg_reg[1] |-> low_freq_range_sel_out == range_strap_in) else $error("range not from strap");
   chk_checker_en: assert property (@(posedge clk_in) disable iff (rst_in)
      crc_check_en_out == crc_check_en_in) else $error("checker enable wrong");
   chk_reserved_zero: assert property (@(posedge clk_in) disable iff (rst_in)
      cfg_reg[6] == 1'b0 && cfg_reg[4] == 1'b0 && bus_ctl_reg[7:5] == 3'h0)
      else $error("reserved bit set");
   chk_write_lands: assert property (@(posedge clk_in) disable iff (rst_in)
      wr_en_in && addr_in == 8'h04 |=> cfg_reg == ($past(wdata_in) & mode_cfg_pkg::cfg_writable))
      else $error("config write lost");

   // ----------------------------------------
   // write decode seen by the checks
   // ----------------------------------------
   logic cfg_wr;
   logic bus_ctl_wr;
   assign cfg_wr = wr_en_in && addr_in == mode_cfg_pkg::cfg_offset;
   assign bus_ctl_wr = wr_en_in && addr_in == mode_cfg_pkg::bus_ctl_offset;

   // ----------------------------------------
   // checks: reset values
   // ----------------------------------------
   // no disable here: these look at the cycle right after a reset edge
   chk_cfg_reset: assert property (@(posedge clk_in)
      rst_in |=> cfg_reg == mode_cfg_pkg::cfg_reset)
      else $error("config reset value wrong");

   chk_ctl_reset: assert property (@(posedge clk_in)
      rst_in |=> bus_ctl_reg == mode_cfg_pkg::bus_ctl_reset)
      else $error("bus control reset value wrong");

   chk_rdata_reset: assert property (@(posedge clk_in)
      rst_in |=> rdata_out == 8'h00)
      else $error("read data not cleared by reset");

   chk_failsafe_reset: assert property (@(posedge clk_in)
      rst_in |=> failsafe_low_out)
      else $error("failsafe not low after reset");

   chk_clear_reset: assert property (@(posedge clk_in)
      rst_in |=> !crc_cnt_clear_out)
      else $error("counter clear set after reset");

   chk_defaults_strap: assert property (@(posedge clk_in)
      rst_in |=> legacy_compat_out == compat_strap_in && low_freq_range_sel_out == range_strap_in)
      else $error("defaults do not follow straps");

   // ----------------------------------------
   // checks: write path
   // ----------------------------------------
   chk_ctl_write_lands: assert property (@(posedge clk_in) disable iff (rst_in)
      bus_ctl_wr |=> bus_ctl_reg == ($past(wdata_in) & mode_cfg_pkg::bus_ctl_writable))
      else $error("bus control write lost");

   // bit 5 included: nothing but a write may drop the counter clear
   chk_cfg_keeps: assert property (@(posedge clk_in) disable iff (rst_in)
      !cfg_wr |=> cfg_reg == $past(cfg_reg))
      else $error("config changed without a write");

   chk_ctl_keeps: assert property (@(posedge clk_in) disable iff (rst_in)
      !bus_ctl_wr |=> bus_ctl_reg == $past(bus_ctl_reg))
      else $error("bus control changed without a write");

   chk_write_other: assert property (@(posedge clk_in) disable iff (rst_in)
      wr_en_in && !cfg_wr && !bus_ctl_wr |=> cfg_reg == $past(cfg_reg) && bus_ctl_reg == $past(bus_ctl_reg))
      else $error("unmapped write changed a register");

   chk_clear_set: assert property (@(posedge clk_in) disable iff (rst_in)
      cfg_wr && wdata_in[mode_cfg_pkg::crc_clear_bit] |=> crc_cnt_clear_out)
      else $error("counter clear not set by write");

   chk_clear_release: assert property (@(posedge clk_in) disable iff (rst_in)
      cfg_wr && !wdata_in[mode_cfg_pkg::crc_clear_bit] |=> !crc_cnt_clear_out)
      else $error("counter clear not released by write");

   chk_failsafe_write: assert property (@(posedge clk_in) disable iff (rst_in)
      cfg_wr |=> failsafe_low_out == $past(wdata_in[mode_cfg_pkg::failsafe_low_bit]))
      else $error("failsafe write not applied");

   chk_compat_write: assert property (@(posedge clk_in) disable iff (rst_in)
      cfg_wr && wdata_in[mode_cfg_pkg::compat_by_reg_bit]
      |=> legacy_compat_out == $past(wdata_in[mode_cfg_pkg::compat_val_bit]))
      else $error("compat bit write not applied");

   chk_range_write: assert property (@(posedge clk_in) disable iff (rst_in)
      cfg_wr && wdata_in[mode_cfg_pkg::range_by_reg_bit]
      |=> low_freq_range_sel_out == $past(wdata_in[mode_cfg_pkg::range_val_bit]))
      else $error("range bit write not applied");

   // ----------------------------------------
   // checks: read path
   // ----------------------------------------
   chk_read_cfg: assert property (@(posedge clk_in) disable iff (rst_in)
      addr_in == mode_cfg_pkg::cfg_offset |=> rdata_out == $past(cfg_reg))
      else $error("config read back wrong");

   chk_read_ctl: assert property (@(posedge clk_in) disable iff (rst_in)
      addr_in == mode_cfg_pkg::bus_ctl_offset |=> rdata_out == $past(bus_ctl_reg))
      else $error("bus control read back wrong");

   chk_read_unmapped: assert property (@(posedge clk_in) disable iff (rst_in)
      addr_in != mode_cfg_pkg::cfg_offset && addr_in != mode_cfg_pkg::bus_ctl_offset |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");

   chk_read_after_write: assert property (@(posedge clk_in) disable iff (rst_in)
      cfg_wr ##1 addr_in == mode_cfg_pkg::cfg_offset
      |=> rdata_out == ($past(wdata_in, 2) & mode_cfg_pkg::cfg_writable))
      else $error("written config not read back");

   // ----------------------------------------
   // checks: one per bit
   // ----------------------------------------
   // reserved bits must stay hidden on the read port, so software always sees zero there
   for (genvar i = 0; i < 8; i = i + 1) begin : g_bit
      if (!mode_cfg_pkg::cfg_writable[i]) begin : g_cfg_res
         chk_cfg_bit_zero: assert property (@(posedge clk_in) disable iff (rst_in)
            addr_in == mode_cfg_pkg::cfg_offset |=> !rdata_out[i])
            else $error("reserved config bit reads one");
      end else begin : g_cfg_rw
         chk_cfg_bit_lands: assert property (@(posedge clk_in) disable iff (rst_in)
            cfg_wr |=> cfg_reg[i] == $past(wdata_in[i]))
            else $error("writable config bit lost");
      end
      if (!mode_cfg_pkg::bus_ctl_writable[i]) begin : g_ctl_res
         chk_ctl_bit_zero: assert property (@(posedge clk_in) disable iff (rst_in)
            addr_in == mode_cfg_pkg::bus_ctl_offset |=> !rdata_out[i])
            else $error("reserved control bit reads one");
      end else begin : g_ctl_rw
         chk_ctl_bit_lands: assert property (@(posedge clk_in) disable iff (rst_in)
            bus_ctl_wr |=> bus_ctl_reg[i] == $past(wdata_in[i]))
            else $error("writable control bit lost");
      end
   end
endmodule
`default_nettype wire

// file: design/mode_cfg_pkg.sv
// Operation
// - bit 7 set: undriven inputs settle low; clear: settle high
// - bit 5 holds crc error counters cleared until software writes it back to 0
// - bit 3 set: legacy_compat taken from bit 2, else from strap pin
// - bit 2 enables legacy_compat only while bit 3 set; default off
// - bit 1 set: frequency range taken from bit 0, else from strap pin
// - bit 0 set selects low range 5 to 15 MHz; default normal 15-85 MHz
// - separate checker-enable bit turns back-channel crc checking on or off
package mode_cfg_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] cfg_offset = 8'h04;
   localparam logic [7:0] bus_ctl_offset = 8'h05;
   localparam logic [7:0] cfg_reset = 8'h80;
   localparam logic [7:0] bus_ctl_reset = 8'h00;
   // bits 6 and 4 are reserved; every other config bit, bit 1 included, is software writable
   localparam logic [7:0] cfg_writable = 8'haf;
   localparam logic [7:0] bus_ctl_writable = 8'h1f;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int failsafe_low_bit = 7;
   localparam int crc_clear_bit = 5;
   localparam int compat_by_reg_bit = 3;
   localparam int compat_val_bit = 2;
   localparam int range_by_reg_bit = 1;
   localparam int range_val_bit = 0;
endpackage

// file: design/cfg_field_sel.sv
`timescale 1ns/10ps
`default_nettype none
module cfg_field_sel (
   input wire logic by_reg_in,
   input wire logic reg_val_in,
   input wire logic strap_in,
   output logic sel_out
);
   // strap is a plain level, so the selected value follows it without extra delay
   assign sel_out = by_reg_in ? reg_val_in : strap_in;
endmodule
`default_nettype wire

// file: testbench/serializer_mode_config_register_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module serializer_mode_config_register_tb_top;
   // ----------------------------------------
   // dut and clock
   // ----------------------------------------
   logic clk_in = 1'b0, rst_in = 1'b1, wr_en_in = 1'b0, cs_in = 1'b0, rs_in = 1'b0, ce_in = 1'b0;
   logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out, cfg, ctl;
   logic fs, cc, ceo, lc, lf;
   int n_mismatch = 0, check_count = 0, cyc = 0;
   mode_cfg_regs u_dut (.clk_in(clk_in), .rst_in(rst_in), .wr_en_in(wr_en_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .rdata_out(rdata_out), .compat_strap_in(cs_in), .range_strap_in(rs_in),
      .crc_check_en_in(ce_in), .failsafe_low_out(fs), .crc_cnt_clear_out(cc), .crc_check_en_out(ceo),
      .legacy_compat_out(lc), .low_freq_range_sel_out(lf));
   initial begin
      forever #10 clk_in = ~clk_in;
   end
   // run needs under 900 cycles, so 2000 means a hang
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_mismatch = n_mismatch + 1;
         end_sim();
      end
   end
   // ----------------------------------------
   // checks and bus tasks
   // ----------------------------------------
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] exp_out(input logic [7:0] c);
      return {3'h0, c[7], c[5], ce_in, c[3] ? c[2] : cs_in, c[1] ? c[0] : rs_in};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_in);
      wr_en_in = 1'b1;
      addr_in = a;
      wdata_in = d;
      @(negedge clk_in);
      wr_en_in = 1'b0;
      if (a == 8'h04) cfg = d & 8'haf;
      if (a == 8'h05) ctl = d & 8'h1f;
   endtask
   // read data is registered, so sample one cycle after the address
   task automatic rd(input logic [7:0] a);
      addr_in = a;
      @(negedge clk_in);
      cmp8(rdata_out, (a == 8'h04) ? cfg : (a == 8'h05) ? ctl : 8'h00);
      cmp8({3'h0, fs, cc, ceo, lc, lf}, exp_out(cfg));
   endtask
   task automatic end_sim();
      $display("counts: checks=%0d mismatches=%0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      logic [7:0] a;
      void'($urandom(32'h1a6f));
      repeat (3) @(negedge clk_in);
      rst_in = 1'b0;
      cfg = 8'h80;
      ctl = 8'h00;
      rd(8'h04);
      rd(8'h05);
      $display("test reset done");
      wr(8'h04, 8'h2f);
      rd(8'h04);
      rd(8'h04);
      // straps high so that register zeros in bits 2 and 0 must win over them
      cs_in = 1'b1;
      rs_in = 1'b1;
      wr(8'h04, 8'h5a);
      rd(8'h04);
      wr(8'h05, 8'hff);
      rd(8'h05);
      rd(8'h06);
      $display("test corners done");
      wr(8'h04, 8'h2f);
      wr(8'h05, 8'h0f);
      rst_in = 1'b1;
      @(negedge clk_in);
      rst_in = 1'b0;
      cfg = 8'h80;
      ctl = 8'h00;
      rd(8'h04);
      rd(8'h05);
      $display("test mid-run reset done");
      repeat (200) begin
         a = 8'h04 + 8'($urandom_range(2));
         cs_in = 1'($urandom);
         rs_in = 1'($urandom);
         ce_in = 1'($urandom);
         wr(a, 8'($urandom));
         rd(a);
      end
      $display("test random done");
      end_sim();
   end
endmodule
`default_nettype wire
